// >>> ulmc_pkg.sv
// Purpose: Constants and carrier types for one serial channel's line and modem control.
// Assumes: Registers reached by a 3-bit address with read and write strobes.
// Notes: Divisor and baud generator sit outside; a 16x tick arrives as an input.
// Contract
// - Format bits 1:0 pick 5, 6, 7 or 8 data bits; reset 00.
// - Bit 2 picks one stop bit, or 1.5 for five bits, else two.
// - Bit 3 adds a parity bit on send and checks it on receive.
// - Bit 4 clear gives odd parity, set gives even parity.
// - Bit 5 with parity forces parity to the inverse of bit 4.
// - Bit 6 holds the serial output low until software clears it; in loop-back tx_pin stays high.
// - Modem bits 0 and 1 drive ready and request pins inverted; in loop-back both pins stay high.
// - Modem bit 3 clear floats the interrupt output; set drives it.
// - Modem bit 4 selects local loop-back; reset clears it.
// - In loop-back, status bits 7:4 mirror modem control outputs.
// - Line bit 0 shows a character waits in the receive holding register.
// - A character ending while holding is full and not read that cycle sets overrun, holding kept.
// - Line bit 2 flags a parity mismatch on the received character.
// - Line bit 3 flags a low line where a stop bit belongs.
// - Line bit 4 flags receive input low for a whole frame.
// - Line bit 5 shows transmit holding empty and requests its interrupt.
// - Line bit 6 is set only when holding and shifter are both empty.
// - Modem bits 3:0 latch input changes; a read clears each one whose input does not change in that read cycle.
// - Ring change sets only on ring input going low to high.
// - Outside loop-back, status bits 7:4 are inverted modem input pins.
// - An eight-bit scratch register reads back what software wrote.
// - Reset clears controls and flags, sets empty flags, drives pins high.
// - Start bit sampled at its midpoint; a high line means false start.
// - Software writes transmit holding only when empty; empty set on transfer.
package ulmc_pkg;
  // ==========================================================
  // Register addresses
  localparam logic [2:0] ULMC_A_DATA = 3'h0;
  localparam logic [2:0] ULMC_A_LFC = 3'h3;
  localparam logic [2:0] ULMC_A_MOC = 3'h4;
  localparam logic [2:0] ULMC_A_LCF = 3'h5;
  localparam logic [2:0] ULMC_A_MIF = 3'h6;
  localparam logic [2:0] ULMC_A_SCR = 3'h7;
  // ==========================================================
  // Field positions
  localparam int ULMC_F_STOP = 2;
  localparam int ULMC_F_PEN = 3;
  localparam int ULMC_F_EVEN = 4;
  localparam int ULMC_F_FORCE = 5;
  localparam int ULMC_F_BRK = 6;
  localparam int ULMC_M_DTR = 0;
  localparam int ULMC_M_RTS = 1;
  localparam int ULMC_M_OUT1 = 2;
  localparam int ULMC_M_OUT2 = 3;
  localparam int ULMC_M_LOOP = 4;
  // ==========================================================
  // Reset values and widths
  localparam logic [7:0] ULMC_RST_ZERO = 8'h00;
  localparam logic [4:0] ULMC_MOC_MASK = 5'h1F;
  localparam logic [6:0] ULMC_LFC_MASK = 7'h7F;
  localparam logic [3:0] ULMC_OVS = 4'hF;   // Last tick of 16x bit
  localparam logic [3:0] ULMC_HALF = 4'h7;  // Midpoint of start bit
  localparam logic [3:0] ULMC_HALF_STOP = 4'h7;
  localparam logic [3:0] ULMC_BASE_BITS = 4'h5;
  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic ring_indicator_n;
    logic carrier_detect_n;
  } ulmc_modem_in_s;
  typedef struct packed {
    logic dtr_n;
    logic rts_n;
    logic user_output_one_n;
    logic user_output_two_n;
  } ulmc_modem_out_s;
  typedef struct packed {
    logic [2:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } ulmc_bus_s;
endpackage

// >>> ulmc_channel.sv
// Purpose: One channel: format control, tx/rx engines, line and modem status.
// Assumes: Serial and modem input pins synchronous to clk after two-flop synchronisers.
// Notes: baud_tick16 is a one-cycle pulse at 16x bit rate from outside.
`timescale 1ns/1ps
module ulmc_channel
  import ulmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic baud_tick16,
  input wire ulmc_bus_s bus,
  output logic [7:0] rdata,
  input wire logic rx_pin,
  output logic tx_pin,
  input wire ulmc_modem_in_s modem_in,
  output ulmc_modem_out_s modem_out,
  input wire logic irq_req,
  output logic irq_out,
  output logic irq_oe,
  output logic tx_ready_evt
);
  // ==========================================================
  // Synchronisers
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  always_ff @(posedge clk) begin
    sync1_reg <= {rx_pin, modem_in};
    sync2_reg <= sync1_reg;
  end

  // ==========================================================
  // Registers
  logic [7:0] lfc_reg;
  logic [7:0] moc_reg;
  logic [7:0] scratch_reg;
  logic [7:0] tx_holding_reg;
  logic thr_full_reg;
  logic [7:0] rx_holding_reg;
  logic ready_reg;
  logic ovr_reg;
  logic par_err_reg;
  logic frm_err_reg;
  logic brk_reg;
  logic [3:0] delta_reg;
  logic [3:0] mstat_prev_reg;

  wire loop = moc_reg[ULMC_M_LOOP];
  wire wr_lfc = bus.wr && bus.addr == ULMC_A_LFC;
  wire wr_moc = bus.wr && bus.addr == ULMC_A_MOC;
  wire wr_scr = bus.wr && bus.addr == ULMC_A_SCR;
  wire wr_thr = bus.wr && bus.addr == ULMC_A_DATA && !lfc_reg[7];
  wire rd_rhr = bus.rd && bus.addr == ULMC_A_DATA && !lfc_reg[7];
  wire rd_lcf = bus.rd && bus.addr == ULMC_A_LCF;
  wire rd_mif = bus.rd && bus.addr == ULMC_A_MIF;

  // Character format decode
  wire [3:0] nbits = ULMC_BASE_BITS + {2'b00, lfc_reg[1:0]};
  wire pen = lfc_reg[ULMC_F_PEN];
  wire two_stop = lfc_reg[ULMC_F_STOP];
  wire half_stop = two_stop && lfc_reg[1:0] == 2'b00;

  // Modem status high half: pins inverted, or controls in loop-back
  wire [3:0] pin_state = ~sync2_reg[3:0]; // order cts,dsr,ri,cd
  wire [3:0] loop_state = {moc_reg[ULMC_M_RTS], moc_reg[ULMC_M_DTR],
                           moc_reg[ULMC_M_OUT1], moc_reg[ULMC_M_OUT2]};
  wire [3:0] mstat = loop ? loop_state : pin_state;
  // Changes: cts,dsr,cd any edge; ring only on its trailing edge
  wire [3:0] chg = mstat ^ mstat_prev_reg;
  wire ri_trail = mstat_prev_reg[1] && !mstat[1];
  wire [3:0] dset = {chg[3], chg[2], ri_trail, chg[0]};
  wire [3:0] dnew = {dset[0], dset[1], dset[2], dset[3]}; // to bits cd,ri,dsr,cts

  // ==========================================================
  // Transmitter
  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001, TX_START = 5'b00010, TX_DATA = 5'b00100,
    TX_PAR = 5'b01000, TX_STOP = 5'b10000
  } ulmc_tx_e;
  ulmc_tx_e tx_state_reg;
  logic [7:0] tx_shifter_reg;
  logic [3:0] tx_tick_reg;
  logic [3:0] tx_cnt_reg;
  logic tx_line_reg;
  logic tx_par_reg;
  wire tx_bit_end = baud_tick16 && tx_tick_reg == ULMC_OVS;
  // Parity over all data bits, including the one leaving now
  wire tx_par_all = tx_par_reg ^ tx_shifter_reg[0];
  // Odd vs even, forced values
  wire tx_par_bit = lfc_reg[ULMC_F_FORCE] ? !lfc_reg[ULMC_F_EVEN]
                                          : (tx_par_all ^ !lfc_reg[ULMC_F_EVEN]);
  wire [3:0] stop_len = two_stop && !half_stop ? 4'h2 : 4'h1;
  wire stop_done = half_stop && tx_cnt_reg == 4'h1 && tx_tick_reg == ULMC_HALF_STOP;
  wire tx_load = tx_state_reg == TX_IDLE && thr_full_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_state_reg <= TX_IDLE;
      tx_shifter_reg <= ULMC_RST_ZERO;
      tx_tick_reg <= 4'h0;
      tx_cnt_reg <= 4'h0;
      tx_line_reg <= 1'b1;
      tx_par_reg <= 1'b0;
    end else begin
      unique case (tx_state_reg)
        TX_IDLE: begin
          tx_line_reg <= 1'b1;
          if (tx_load) begin
            tx_shifter_reg <= tx_holding_reg;
            tx_tick_reg <= 4'h0;
            tx_par_reg <= 1'b0;
            tx_state_reg <= TX_START;
            tx_line_reg <= 1'b0;
          end
        end
        TX_START: begin
          if (baud_tick16) tx_tick_reg <= tx_tick_reg + 4'h1;
          if (tx_bit_end) begin
            tx_state_reg <= TX_DATA;
            tx_cnt_reg <= 4'h0;
            tx_line_reg <= tx_shifter_reg[0];
          end
        end
        TX_DATA: begin
          if (baud_tick16) tx_tick_reg <= tx_tick_reg + 4'h1;
          if (tx_bit_end) begin
            tx_par_reg <= tx_par_reg ^ tx_shifter_reg[0];
            tx_shifter_reg <= {1'b0, tx_shifter_reg[7:1]};
            tx_cnt_reg <= tx_cnt_reg + 4'h1;
            if (tx_cnt_reg + 4'h1 == nbits) begin
              tx_state_reg <= pen ? TX_PAR : TX_STOP;
              tx_line_reg <= pen ? tx_par_bit : 1'b1;
              tx_cnt_reg <= 4'h0;
            end else begin
              tx_line_reg <= tx_shifter_reg[1];
            end
          end
        end
        TX_PAR: begin
          if (baud_tick16) tx_tick_reg <= tx_tick_reg + 4'h1;
          if (tx_bit_end) begin
            tx_state_reg <= TX_STOP;
            tx_line_reg <= 1'b1;
            tx_cnt_reg <= 4'h0;
          end
        end
        TX_STOP: begin
          if (baud_tick16) tx_tick_reg <= tx_tick_reg + 4'h1;
          if (tx_bit_end) tx_cnt_reg <= tx_cnt_reg + 4'h1;
          if ((tx_bit_end && tx_cnt_reg + 4'h1 == stop_len && !half_stop) ||
              (baud_tick16 && stop_done)) begin
            tx_state_reg <= TX_IDLE;
          end
        end
      endcase
    end
  end

  wire tx_serial = lfc_reg[ULMC_F_BRK] ? 1'b0 : tx_line_reg;

  // ==========================================================
  // Receiver
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_BITS = 4'b0100, RX_STOP = 4'b1000
  } ulmc_rx_e;
  ulmc_rx_e rx_state_reg;
  logic [3:0] rx_tick_reg;
  logic [3:0] rx_cnt_reg;
  logic [8:0] rx_shifter_reg;
  logic rx_all_low_reg;
  logic rx_prev_reg;
  // Loop-back routes tx internally
  wire rx_in = loop ? tx_serial : sync2_reg[4];
  wire rx_mid = baud_tick16 && rx_tick_reg == ULMC_HALF;
  wire [3:0] rx_total = nbits + {3'b000, pen};
  // Received data justified to bit 0, parity taken out
  wire [8:0] rx_just = rx_shifter_reg >> (4'h9 - rx_total);
  wire [7:0] rx_data = rx_just[7:0] & ~(8'hFF << nbits);
  wire rx_par_rx = rx_just[nbits];
  wire rx_par_exp = lfc_reg[ULMC_F_FORCE] ? !lfc_reg[ULMC_F_EVEN]
                                          : (^rx_data) ^ !lfc_reg[ULMC_F_EVEN];
  // Stop bit is judged at its own midpoint, a full bit after the last data or parity sample
  wire rx_done = rx_state_reg == RX_STOP && baud_tick16 && rx_tick_reg == ULMC_OVS;
  // Only a falling edge starts a frame, so a low stop or break cannot retrigger
  wire rx_fall = rx_prev_reg && !rx_in;

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_state_reg <= RX_IDLE;
      rx_tick_reg <= 4'h0;
      rx_cnt_reg <= 4'h0;
      rx_shifter_reg <= 9'h000;
      rx_all_low_reg <= 1'b0;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_prev_reg <= rx_in;
      if (baud_tick16) rx_tick_reg <= rx_tick_reg + 4'h1;
      unique case (rx_state_reg)
        RX_IDLE: begin
          rx_tick_reg <= 4'h0;
          if (rx_fall) rx_state_reg <= RX_START;
        end
        RX_START: begin
          if (rx_mid) begin
            rx_tick_reg <= 4'h0;
            rx_cnt_reg <= 4'h0;
            rx_all_low_reg <= 1'b1;
            rx_state_reg <= rx_in ? RX_IDLE : RX_BITS;
          end
        end
        RX_BITS: begin
          if (baud_tick16 && rx_tick_reg == ULMC_OVS) begin
            rx_shifter_reg <= {rx_in, rx_shifter_reg[8:1]};
            rx_all_low_reg <= rx_all_low_reg & !rx_in;
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
            if (rx_cnt_reg + 4'h1 == rx_total) rx_state_reg <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_done) rx_state_reg <= RX_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Register file and status flags
  wire rx_brk = rx_done && rx_all_low_reg && !rx_in;
  always_ff @(posedge clk) begin
    if (rst) begin
      lfc_reg <= ULMC_RST_ZERO;
      moc_reg <= ULMC_RST_ZERO;
      scratch_reg <= ULMC_RST_ZERO;
      tx_holding_reg <= ULMC_RST_ZERO;
      thr_full_reg <= 1'b0;
      rx_holding_reg <= ULMC_RST_ZERO;
      ready_reg <= 1'b0;
      ovr_reg <= 1'b0;
      par_err_reg <= 1'b0;
      frm_err_reg <= 1'b0;
      brk_reg <= 1'b0;
      delta_reg <= 4'h0;
      mstat_prev_reg <= 4'h0;
    end else begin
      if (wr_lfc) lfc_reg <= {1'b0, bus.wdata[6:0] & ULMC_LFC_MASK};
      if (wr_moc) moc_reg <= {3'b000, bus.wdata[4:0] & ULMC_MOC_MASK};
      if (wr_scr) scratch_reg <= bus.wdata;
      if (wr_thr) begin
        tx_holding_reg <= bus.wdata;
        thr_full_reg <= 1'b1;
      end else if (tx_load) begin
        thr_full_reg <= 1'b0;
      end
      // Receive flags: error sets win over status read clears; a data read in the ending cycle clears ready and blocks overrun
      if (rx_done && !ready_reg) begin
        rx_holding_reg <= rx_data;
        ready_reg <= 1'b1;
      end else if (rd_rhr) begin
        ready_reg <= 1'b0;
      end
      if (rx_done && ready_reg && !rd_rhr) ovr_reg <= 1'b1;
      else if (rd_lcf) ovr_reg <= 1'b0;
      if (rx_done && pen && rx_par_rx != rx_par_exp) par_err_reg <= 1'b1;
      else if (rd_lcf) par_err_reg <= 1'b0;
      if (rx_done && !rx_in) frm_err_reg <= 1'b1;
      else if (rd_lcf) frm_err_reg <= 1'b0;
      if (rx_brk) brk_reg <= 1'b1;
      else if (rd_lcf) brk_reg <= 1'b0;
      // Delta bits: change wins over clearing read
      mstat_prev_reg <= mstat;
      delta_reg <= (rd_mif ? 4'h0 : delta_reg) | dnew;
    end
  end

  wire thr_empty = !thr_full_reg;
  wire tx_empty = thr_empty && tx_state_reg == TX_IDLE;
  wire [7:0] lcf_val = {1'b0, tx_empty, thr_empty, brk_reg, frm_err_reg,
                        par_err_reg, ovr_reg, ready_reg};
  wire [7:0] mif_val = {mstat[0], mstat[1], mstat[2], mstat[3], delta_reg};
  assign tx_ready_evt = thr_empty;

  // Read mux
  always_ff @(posedge clk) begin
    if (rst) rdata <= ULMC_RST_ZERO;
    else if (bus.rd) begin
      unique case (bus.addr)
        ULMC_A_DATA: rdata <= rx_holding_reg;
        ULMC_A_LFC: rdata <= lfc_reg;
        ULMC_A_MOC: rdata <= moc_reg;
        ULMC_A_LCF: rdata <= lcf_val;
        ULMC_A_MIF: rdata <= mif_val;
        ULMC_A_SCR: rdata <= scratch_reg;
        default: rdata <= ULMC_RST_ZERO;
      endcase
    end
  end

  // ==========================================================
  // Pins
  assign tx_pin = loop ? 1'b1 : tx_serial;
  assign modem_out.dtr_n = loop | !moc_reg[ULMC_M_DTR];
  assign modem_out.rts_n = loop | !moc_reg[ULMC_M_RTS];
  assign modem_out.user_output_one_n = loop | !moc_reg[ULMC_M_OUT1];
  assign modem_out.user_output_two_n = loop | !moc_reg[ULMC_M_OUT2];
  assign irq_out = irq_req;
  assign irq_oe = moc_reg[ULMC_M_OUT2];
endmodule // ulmc_channel

// >>> ulmc_channel_asserts.sv
// Purpose: Port checks for one serial channel.
// Assumes: Format bit 7 never set; no read and write in one cycle.
// Notes: Shadows of the control registers follow bus writes.
`timescale 1ns/1ps
module ulmc_channel_chk
  import ulmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire ulmc_bus_s bus,
  input wire logic [7:0] rdata,
  input wire logic tx_pin,
  input wire ulmc_modem_out_s modem_out,
  input wire logic irq_oe,
  input wire logic tx_ready_evt
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ==========================================================
  // Shadow controls
  logic [7:0] lfc_reg;
  logic [7:0] moc_reg;
  wire logic rd_mif = bus.rd && bus.addr == ULMC_A_MIF;
  always_ff @(posedge clk) begin
    if (rst) begin
      lfc_reg <= 8'h00;
      moc_reg <= 8'h00;
    end else if (bus.wr && bus.addr == ULMC_A_LFC) begin
      lfc_reg <= bus.wdata & 8'h7F;
    end else if (bus.wr && bus.addr == ULMC_A_MOC) begin
      moc_reg <= bus.wdata & 8'h1F;
    end
  end
  // ==========================================================
  // Assertions
  brk_hold_a: assert property (lfc_reg[6] && !moc_reg[4] |-> !tx_pin)
    else $error("break not driven low");
  ctl_pins_a: assert property (!moc_reg[4] |-> modem_out.dtr_n == !moc_reg[0]
    && modem_out.rts_n == !moc_reg[1]) else $error("ready or request pin wrong");
  irq_drive_a: assert property (irq_oe == moc_reg[3])
    else $error("interrupt enable wrong");
  loop_idle_a: assert property (moc_reg[4] |-> tx_pin && modem_out == 4'hF)
    else $error("pins active in loop-back");
  fmt_read_a: assert property (bus.rd && bus.addr == ULMC_A_LFC |=> rdata == lfc_reg)
    else $error("format readback wrong");
  moc_read_a: assert property (bus.rd && bus.addr == ULMC_A_MOC |=> rdata == moc_reg)
    else $error("modem control readback wrong");
  loop_status_a: assert property (rd_mif && moc_reg[4] |=>
    rdata[7:4] == {moc_reg[3], moc_reg[2], moc_reg[0], moc_reg[1]}) else $error("loop status");
  thr_full_a: assert property (bus.wr && bus.addr == ULMC_A_DATA |=> !tx_ready_evt)
    else $error("holding empty after write");
  reset_pins_a: assert property ($fell(rst) |-> tx_pin && modem_out == 4'hF && !irq_oe)
    else $error("pins wrong after reset");
  brk_c: cover property (lfc_reg[6] && !tx_pin);
  loop_c: cover property (rd_mif && moc_reg[4]);
  send_c: cover property (bus.wr && bus.addr == ULMC_A_DATA);
endmodule // ulmc_channel_chk
bind ulmc_channel ulmc_channel_chk u_chk (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
  .tx_pin(tx_pin), .modem_out(modem_out), .irq_oe(irq_oe), .tx_ready_evt(tx_ready_evt));

// >>> ulmc_remote.sv
// Purpose: Remote serial device on the line side.
// Assumes: Bit time is BIT_CLKS cycles; tasks called on a rising edge.
// Notes: Line idles high; frames may carry bad parity or stop.
`timescale 1ns/1ps
module ulmc_remote #(parameter int BIT_CLKS = 64) (
  input wire logic clk,
  input wire logic tx_pin,
  output logic rx_line
);
  initial rx_line = 1'b1;
  // ==========================================================
  // Line driver and sampler
  task automatic put(input logic b);
    rx_line <= b;
    repeat (BIT_CLKS) @(posedge clk);
  endtask
  task automatic send(input logic [7:0] d, input logic p, input logic sv);
    @(posedge clk);
    put(1'b0);
    for (int i = 0; i < 8; i++) put(d[i]);
    put(p);
    put(sv);
    put(1'b1);
  endtask
  task automatic glitch();
    @(posedge clk);
    rx_line <= 1'b0;
    repeat (BIT_CLKS / 4) @(posedge clk);
    rx_line <= 1'b1;
  endtask
  task automatic catch(input int nb, input int pen, output logic [7:0] d, output logic [2:0] f);
    int n;
    n = 0;
    d = 8'h00;
    while (tx_pin !== 1'b0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    repeat (BIT_CLKS / 2) @(posedge clk);
    f[0] = tx_pin;
    for (int i = 0; i < nb; i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      d[i] = tx_pin;
    end
    repeat (BIT_CLKS * pen) @(posedge clk);
    f[1] = tx_pin;
    repeat (BIT_CLKS) @(posedge clk);
    f[2] = tx_pin;
  endtask
endmodule // ulmc_remote

// >>> tb_uart_line_modem_control.sv
// Purpose: Self-checking bench for one serial channel.
// Assumes: A 16x tick every 4 cycles, so a bit is 64 cycles.
// Notes: Expected values come from a small model in the bench.
`timescale 1ns/1ps
module tb_uart_line_modem_control
  import ulmc_pkg::*;
;
  logic clk, rst, baud_tick16, tx_pin, rx_pin, irq_req, irq_out, irq_oe, tx_ready_evt;
  logic [7:0] rdata, v, rnd, lfc, dm, d;
  logic [2:0] f;
  logic [1:0] tick_cnt;
  logic ep;
  ulmc_bus_s bus;
  ulmc_modem_in_s modem_in, om;
  ulmc_modem_out_s modem_out;
  int error_cnt, total_checks;
  logic [7:0] rx_q[$];
  ulmc_channel DUT (.clk(clk), .rst(rst), .baud_tick16(baud_tick16), .bus(bus),
    .rdata(rdata), .rx_pin(rx_pin), .tx_pin(tx_pin), .modem_in(modem_in),
    .modem_out(modem_out), .irq_req(irq_req), .irq_out(irq_out), .irq_oe(irq_oe),
    .tx_ready_evt(tx_ready_evt));
  ulmc_remote #(.BIT_CLKS(64)) p (.clk(clk), .tx_pin(tx_pin), .rx_line(rx_pin));
  // ==========================================================
  // Clock and tick
  always #5 clk = ~clk;
  always @(posedge clk) begin
    tick_cnt <= tick_cnt + 2'h1;
    baud_tick16 <= tick_cnt == 2'h3;
  end
  function automatic logic [7:0] nx(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] x);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= x;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] x);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 x = rdata;
  endtask
  task automatic wait_bit(input int b);
    int n;
    n = 0;
    do begin
      rd(ULMC_A_LCF, v);
      n++;
    end while (v[b] !== 1'b1 && n < 600);
  endtask
  task automatic rx_case(input logic [7:0] x, input logic pb, input logic sv, input int b);
    p.send(x, pb, sv);
    repeat (20) @(posedge clk);
    rd(ULMC_A_LCF, v);
    chk({7'h0, v[b]}, 8'h01);
    rd(ULMC_A_DATA, v);
    if (b == 0) chk(v, x);
  endtask
  task automatic conclude();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #800000;
    error_cnt++;
    conclude();
  end
  // ==========================================================
  // Main sequence
  initial begin
    {clk, baud_tick16, irq_req, tick_cnt, error_cnt, total_checks} = '0;
    rst = 1'b1;
    bus = '0;
    modem_in = 4'hF;
    rnd = 8'h14;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(ULMC_A_LFC, v);
    chk(v, 8'h00);
    rd(ULMC_A_LCF, v);
    chk(v, 8'h60);
    rd(ULMC_A_MIF, v);
    chk(v, 8'h00);
    rd(3'h1, v);
    chk(v, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rnd = nx(rnd);
      wr(ULMC_A_SCR, rnd);
      rd(ULMC_A_SCR, v);
      chk(v, rnd);
    end
    // Every length with every parity code, stop bit toggled
    for (int w = 0; w < 4; w++) begin
      for (int m = 0; m < 5; m++) begin
        lfc = 8'(w) | (m == 0 ? 8'h00 : 8'h08 | 8'((m - 1) << 4)) | 8'((m & 1) << 2);
        rnd = nx(rnd);
        dm = rnd & (8'hFF >> (3 - w));
        ep = lfc[5] ? ~lfc[4] : (lfc[4] ? ^dm : ~^dm);
        wr(ULMC_A_LFC, lfc);
        wr(ULMC_A_DATA, rnd);
        rd(ULMC_A_LCF, v);
        chk({7'h0, v[6]}, 8'h00);
        p.catch(5 + w, int'(lfc[3]), d, f);
        chk({6'h0, f[2], f[0]}, 8'h02);
        chk(d, dm);
        if (lfc[3]) chk({7'h0, f[1]}, {7'h0, ep});
        wait_bit(6);
        chk(v, 8'h60);
      end
    end
    wr(ULMC_A_LFC, 8'h43);
    repeat (20) @(posedge clk);
    chk({7'h0, tx_pin}, 8'h00);
    wr(ULMC_A_LFC, 8'h1B);
    #1 chk({7'h0, tx_pin}, 8'h01);
    // Receive: good, bad parity, bad stop, break, overrun, false start
    rx_case(8'hA5, 1'b0, 1'b1, 0);
    rx_case(8'h5B, 1'b0, 1'b1, 2);
    rx_case(8'h33, 1'b0, 1'b0, 3);
    rx_case(8'h00, 1'b0, 1'b0, 4);
    p.send(8'h3C, 1'b0, 1'b1);
    rx_case(8'hC3, 1'b0, 1'b1, 1);
    chk(v, 8'h3C);
    p.glitch();
    repeat (800) @(posedge clk);
    rd(ULMC_A_LCF, v);
    chk({7'h0, v[0]}, 8'h00);
    // Loop-back in random formats
    for (int i = 0; i < 4; i++) begin
      wait_bit(6);
      rnd = nx(rnd);
      lfc = rnd & 8'h3F;
      wr(ULMC_A_LFC, lfc);
      wr(ULMC_A_MOC, 8'h10 | (rnd & 8'h0F));
      rnd = nx(rnd);
      rx_q.push_back(rnd & (8'hFF >> (3 - lfc[1:0])));
      wr(ULMC_A_DATA, rnd);
      wait_bit(0);
      rd(ULMC_A_DATA, v);
      chk(v, rx_q.pop_front());
      rd(ULMC_A_MIF, v);
    end
    wr(ULMC_A_MOC, 8'h00);
    wr(ULMC_A_LFC, 8'h03);
    rd(ULMC_A_MIF, v);
    // Modem inputs: levels, change latches and clear on read
    for (int i = 0; i < 8; i++) begin
      rnd = nx(rnd);
      om = modem_in;
      @(posedge clk);
      modem_in <= rnd[3:0];
      irq_req <= rnd[4];
      wr(ULMC_A_MOC, {4'h0, rnd[7:4]});
      repeat (4) @(posedge clk);
      rd(ULMC_A_MIF, v);
      chk(v, {~rnd[0], ~rnd[1], ~rnd[2], ~rnd[3], om[0] ^ rnd[0],
        ~om[1] & rnd[1], om[2] ^ rnd[2], om[3] ^ rnd[3]});
      rd(ULMC_A_MIF, v);
      chk({4'h0, v[3:0]}, 8'h00);
      chk({7'h0, irq_out}, {7'h0, rnd[4]});
    end
    conclude();
  end
endmodule // tb_uart_line_modem_control
